// ===== logic/sar_adc_pkg.sv
// Purpose: Shared constants, field layout and state type of the converter control
// Assumes: Avalon-MM byte addresses, one 32-bit word per register, data in bits 7:0
// Notes: Trigger source 0 selects the conversion done flag (free running)
package sar_adc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_CTRL_A = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_INSEL = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_RES_LO = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_RES_HI = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_POWER = 5'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CA_ENABLE = 7;
  localparam int CA_START = 6;
  localparam int CA_AUTO = 5;
  localparam int CA_DONE = 4;
  localparam int CA_IRQEN = 3;
  localparam int IS_LEFT = 5;
  localparam int PW_GATE = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_DIVSEL = 3'h0;
  localparam logic [2:0] RST_TRIGSEL = 3'h0;
  localparam logic RST_POWER_GATE = 1'b0;

  // ----------------------------------------------------------------
  // Trigger sources and timing counts (converter clock cycles)
  // ----------------------------------------------------------------
  localparam int TRIG_N = 8;
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
  localparam int MIN_CPU_KHZ = 100;
  localparam logic [4:0] NORMAL_CYCLES = 5'h0D;
  localparam logic [4:0] FIRST_CYCLES = 5'h19;
  localparam logic [4:0] NORMAL_SH_CYCLE = 5'h01;
  localparam logic [4:0] FIRST_SH_CYCLE = 5'h0D;
  localparam logic [4:0] AUTO_SH_CYCLE = 5'h02;
  localparam logic [4:0] AUTO_END_CYCLE = 5'h0D;

  typedef enum logic [1:0]
  {
    CONV_IDLE = 2'b00,
    CONV_PEND = 2'b01,
    CONV_RUN = 2'b10
  } conv_state_t;

  // Values handed to the analog front end
  typedef struct packed {
    logic [1:0] reference;
    logic [3:0] channel;
  } analog_sel_t;

  typedef struct packed {
    logic waitReq;
    logic [31:0] rdata;
    logic enable;
    logic autoEn;
    logic doneFlag;
    logic irqEn;
    logic [2:0] divSel;
    logic [2:0] trigSel;
    analog_sel_t selWr;
    analog_sel_t selAct;
    logic leftAdj;
    logic powerGate;
    logic [9:0] result;
    logic resultBlocked;
    logic [6:0] presc;
    conv_state_t state;
    logic [4:0] cycCnt;
    logic firstConv;
    logic firstPend;
    logic autoConv;
    logic busy;
    logic [TRIG_N-1:0] trigS1;
    logic [TRIG_N-1:0] trigS2;
    logic [TRIG_N-1:0] trigPrev;
    logic haltPrev;
    logic sampleHold;
    logic irq;
  } state_t;

endpackage : sar_adc_pkg

// ===== logic/sar_adc_conversion_control.sv
// Purpose: Conversion control of a 10-bit successive approximation converter
// Assumes: ref_clk is the CPU clock; analog result valid at conversion completion
// Notes: Registers reached over Avalon-MM, one wait state on every access
//
// Summary of operation
// - Start bit write with power gate clear begins conversion, self-clears at end.
// - Channel change during conversion takes effect only after it completes.
// - Auto trigger edge on selected source resets prescaler, starts conversion.
// - Trigger still high at completion or edges during conversion start nothing.
// - Trigger flags set regardless of interrupt enables; software clears them.
// - Done flag as source restarts after every conversion; first needs software.
// - Start bit reads one while converting; writing it starts one conversion.
// - Prescaler counts while enable set and power gate clear, held in reset otherwise.
// - Prescaler divides CPU clock by ratio from divider select field.
// - Software start begins at next rising converter clock edge.
// - Normal conversion 13 cycles; first software or sleep start after enabling 25 cycles.
// - Sample-and-hold 1.5 cycles in normal, 13.5 cycles in first conversion.
// - Completion writes result, sets done flag, clears start in single mode.
// - Auto conversion samples 2 cycles after trigger, lasts 13.5 cycles.
// - Free running restarts immediately and keeps start bit high.
// - Channel and reference buffered; locked at start, track in last cycle.
// - Free running channel change shows in the second following result.
// - Halted CPU in noise-reduction or idle sleep starts a conversion.
// - Completion interrupt raised even if CPU woke earlier.
// - Other sleep modes leave the converter enabled.
// - Clearing enable during conversion terminates it.
// - Low byte read blocks result updates until high byte read.
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
module sar_adc_conversion_control
  import sar_adc_pkg::*;
(
  input wire logic ref_clk,                                  // CPU clock
  input wire logic rst_n,                                    // Async reset
  input wire logic [sar_adc_pkg::ADDR_W-1:0] avs_address,    // Byte address
  input wire logic avs_read,                                 // Read request
  input wire logic avs_write,                                // Write request
  input wire logic [31:0] avs_writedata,                     // Write data
  input wire logic [3:0] avs_byteenable,                     // Byte lanes
  output logic [31:0] avs_readdata,                          // Read data
  output logic avs_waitrequest,                              // Stall
  input wire logic [sar_adc_pkg::TRIG_N-1:0] trigIn,         // Trigger levels
  input wire logic cpuHalted,                                // CPU halted by sleep
  input wire logic sleepNoiseMode,                           // Idle or noise reduction
  input wire logic [9:0] resultIn,                           // Front end result
  output sar_adc_pkg::analog_sel_t analogSel,                // Buffered selection
  output logic sampleHold,                                   // Sample pulse
  output logic convBusy,                                     // Conversion running
  output logic firstConv,                                    // Long init conversion
  output logic convIrq                                       // Completion interrupt
);
  import sar_adc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic regHit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    regHit = (addr == ofs);
  endfunction : regHit

  function automatic logic [7:0] divRatio(input logic [2:0] sel);
    logic [7:0] r;
    r = 8'h01 << sel;
    if (sel == 3'h0)
    begin
      r = 8'h02;
    end
    divRatio = r;
  endfunction : divRatio

  function automatic logic [4:0] lockEnd(input logic autoC, input logic first);
    logic [4:0] e;
    e = NORMAL_CYCLES - 5'h01;
    if (autoC)
    begin
      e = AUTO_END_CYCLE - 5'h01;
    end
    else if (first)
    begin
      e = FIRST_CYCLES - 5'h01;
    end
    lockEnd = e;
  endfunction : lockEnd

  state_t s;
  state_t n;

  logic [7:0] ratio;
  logic riseTick;
  logic halfTick;
  logic req;
  logic commitWr;
  logic commitRd;
  logic [7:0] wd;
  logic trigEdge;
  logic sleepStart;
  logic swStart;
  logic canRun;
  logic complete;
  logic freeRun;
  logic [4:0] total;
  logic [4:0] shAt;
  logic [4:0] cycNext;
  logic [7:0] resLo;
  logic [7:0] resHi;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n = s;
    ratio = divRatio(s.divSel);
    riseTick = ({1'b0, s.presc} == (ratio - 8'h01));
    halfTick = ({1'b0, s.presc} == ((ratio >> 1) - 8'h01));
    req = avs_read || avs_write;
    commitWr = avs_write && !s.waitReq && avs_byteenable[0];
    commitRd = avs_read && !s.waitReq;
    wd = avs_writedata[7:0];
    swStart = 1'b0;
    complete = 1'b0;
    n.sampleHold = 1'b0;
    freeRun = s.autoEn && (s.trigSel == TRIG_FREE_RUN);
    total = s.firstConv ? FIRST_CYCLES : NORMAL_CYCLES;
    shAt = s.firstConv ? FIRST_SH_CYCLE : NORMAL_SH_CYCLE;
    cycNext = s.cycCnt + 5'h01;
    resLo = s.leftAdj ? {s.result[1:0], 6'h00} : s.result[7:0];
    resHi = s.leftAdj ? s.result[9:2] : {6'h00, s.result[9:8]};

    // ----------------------------------------------------------------
    // Bus slave: one wait state, write and read side effects at accept
    // ----------------------------------------------------------------
    n.waitReq = !(req && s.waitReq);
    if (avs_read && s.waitReq)
    begin
      n.rdata = 32'h0000_0000;
      if (regHit(avs_address, OFS_CTRL_A))
      begin
        n.rdata[7:0] = {s.enable, (s.state != CONV_IDLE), s.autoEn, s.doneFlag, s.irqEn, s.divSel};
      end
      else if (regHit(avs_address, OFS_CTRL_B))
      begin
        n.rdata[7:0] = {5'h00, s.trigSel};
      end
      else if (regHit(avs_address, OFS_INSEL))
      begin
        n.rdata[7:0] = {s.selWr.reference, s.leftAdj, 1'b0, s.selWr.channel};
      end
      else if (regHit(avs_address, OFS_RES_LO))
      begin
        n.rdata[7:0] = resLo;
      end
      else if (regHit(avs_address, OFS_RES_HI))
      begin
        n.rdata[7:0] = resHi;
      end
      else if (regHit(avs_address, OFS_POWER))
      begin
        n.rdata[7:0] = {7'h00, s.powerGate};
      end
    end

    // low byte read locks the pair
    if (commitRd && regHit(avs_address, OFS_RES_LO))
    begin
      n.resultBlocked = 1'b1;
    end
    if (commitRd && regHit(avs_address, OFS_RES_HI))
    begin
      n.resultBlocked = 1'b0;
    end

    if (commitWr && regHit(avs_address, OFS_CTRL_A))
    begin
      n.enable = wd[CA_ENABLE];
      n.autoEn = wd[CA_AUTO];
      n.irqEn = wd[CA_IRQEN];
      n.divSel = wd[2:0];
      swStart = wd[CA_START];
      // Writing one clears the done flag
      if (wd[CA_DONE])
      begin
        n.doneFlag = 1'b0;
      end
    end
    if (commitWr && regHit(avs_address, OFS_CTRL_B))
    begin
      n.trigSel = wd[2:0];
    end
    if (commitWr && regHit(avs_address, OFS_INSEL))
    begin
      n.selWr.reference = wd[7:6];
      n.leftAdj = wd[IS_LEFT];
      n.selWr.channel = wd[3:0];
    end
    if (commitWr && regHit(avs_address, OFS_POWER))
    begin
      n.powerGate = wd[PW_GATE];
    end

    // enabling arms the long first conversion
    if (!s.enable && n.enable)
    begin
      n.firstPend = 1'b1;
    end

    // ----------------------------------------------------------------
    // Trigger synchronisers and edge detection
    // ----------------------------------------------------------------
    n.trigS1 = trigIn;
    n.trigS2 = s.trigS1;
    n.trigPrev = s.trigS2;
    // rising edge of the selected level
    trigEdge = s.trigS2[s.trigSel] && !s.trigPrev[s.trigSel];
    n.haltPrev = cpuHalted;
    // halt in a quiet sleep mode starts a conversion
    // other sleep modes neither start nor disable
    sleepStart = cpuHalted && !s.haltPrev && sleepNoiseMode;

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    // held at zero while disabled
    if (!s.enable || s.powerGate || riseTick)
    begin
      n.presc = 7'h00;
    end
    else
    begin
      n.presc = s.presc + 7'h01;
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    // power gate blocks every start
    canRun = n.enable && !n.powerGate;
    case (s.state)
      CONV_IDLE:
      begin
        // software start works even in auto mode
        if (canRun && (swStart || sleepStart))
        begin
          n.state = CONV_PEND;
        end
        // trigger edge resets prescaler and starts
        else if (canRun && s.autoEn && (s.trigSel != TRIG_FREE_RUN) && trigEdge)
        begin
          n.presc = 7'h00;
          n.state = CONV_RUN;
          n.cycCnt = 5'h00;
          n.autoConv = 1'b1;
          n.firstConv = 1'b0;
        end
      end
      CONV_PEND:
      begin
        // begins on the next converter clock rise
        if (riseTick)
        begin
          n.state = CONV_RUN;
          n.cycCnt = 5'h00;
          n.autoConv = 1'b0;
          n.firstConv = s.firstPend;
          n.firstPend = 1'b0;
        end
      end
      CONV_RUN:
      begin
        if (s.autoConv)
        begin
          if (riseTick)
          begin
            n.cycCnt = cycNext;
          end
          if (riseTick && (cycNext == AUTO_SH_CYCLE))
          begin
            n.sampleHold = 1'b1;
          end
          if (halfTick && (s.cycCnt == AUTO_END_CYCLE))
          begin
            complete = 1'b1;
          end
        end
        else
        begin
          if (halfTick && (s.cycCnt == shAt))
          begin
            n.sampleHold = 1'b1;
          end
          if (riseTick)
          begin
            n.cycCnt = cycNext;
          end
          if (riseTick && (cycNext == total))
          begin
            complete = 1'b1;
          end
        end
        if (complete)
        begin
          if (!s.resultBlocked)
          begin
            n.result = resultIn;
          end
          // flag set whatever the interrupt enables
          n.doneFlag = 1'b1;
          n.firstConv = 1'b0;
          // done flag source restarts at once
          if (freeRun)
          begin
            n.state = riseTick ? CONV_RUN : CONV_PEND;
            n.cycCnt = 5'h00;
            n.autoConv = 1'b0;
            n.firstConv = 1'b0;
          end
          else
          begin
            n.state = CONV_IDLE;
          end
        end
      end
      default:
      begin
        n.state = CONV_IDLE;
      end
    endcase

    if (!n.enable || n.powerGate)
    begin
      n.state = CONV_IDLE;
      n.firstConv = 1'b0;
      n.sampleHold = 1'b0;
    end

    // ----------------------------------------------------------------
    // Selection buffer and outputs
    // ----------------------------------------------------------------
    // track unless locked by a running conversion
    // locked selection keeps the old channel
    if (!((n.state == CONV_RUN) && (n.cycCnt < lockEnd(n.autoConv, n.firstConv))))
    begin
      // restart locks the selection held at completion
      n.selAct = n.selWr;
    end
    n.busy = (n.state == CONV_RUN);
    // request follows the flag, not the CPU state
    n.irq = n.doneFlag && n.irqEn;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Every field not named below resets to zero
      s <= '0;
      s.waitReq <= 1'b1;
      s.divSel <= RST_DIVSEL;
      s.trigSel <= RST_TRIGSEL;
      s.powerGate <= RST_POWER_GATE;
      s.state <= CONV_IDLE;
    end
    else
    begin
      s <= n;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitReq;
  assign analogSel = s.selAct;
  assign sampleHold = s.sampleHold;
  assign convBusy = s.busy;
  assign firstConv = s.firstConv;
  assign convIrq = s.irq;

endmodule : sar_adc_conversion_control

// ===== verif/sar_adc_conversion_control_chk.sv
// Purpose: Port level assertions of the converter control
// Assumes: One clock domain, rst_n asynchronous and active low
// Notes: Bounds are wide enough for every divider setting
module sar_adc_conversion_control_chk
(
  input wire logic ref_clk,          // CPU clock
  input wire logic rst_n,            // Async reset
  input wire logic avs_read,         // Read request
  input wire logic avs_write,        // Write request
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest,  // Stall
  input wire logic [5:0] analogSel,  // Buffered selection
  input wire logic sampleHold,       // Sample pulse
  input wire logic convBusy,         // Conversion running
  input wire logic firstConv         // Long init conversion
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Slowest case: first conversion at the largest divider, 13.5 x 128 cycles
  localparam int SH_LIMIT = 1800;
  int shWait;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shWait <= 0;
    end
    else if (!convBusy || sampleHold)
    begin
      shWait <= 0;
    end
    else
    begin
      shWait <= shWait + 1;
    end
  end
  // ----------------------------------------------------------------
  // Handshake and conversion shape
  // ----------------------------------------------------------------
  sequence seqAck;
    ##[1:2] !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence seqLocked;
    (!convBusy || $stable(analogSel)) [*8];
  endsequence
  AST_BUS_ACK: assert property ($rose(avs_read || avs_write) |-> seqAck)
    else $error("Bus request not answered in time");
  AST_RDATA_HI: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("Upper read data bits not zero");
  AST_SH_PULSE: assert property (sampleHold |=> !sampleHold)
    else $error("Sample pulse longer than one cycle");
  AST_SH_BUSY: assert property (sampleHold |-> convBusy)
    else $error("Sample pulse outside a conversion");
  AST_FIRST_BUSY: assert property (firstConv |-> convBusy)
    else $error("First conversion mark without conversion");
  AST_SEL_LOCK: assert property ($rose(convBusy) |=> seqLocked)
    else $error("Selection changed early in a conversion");
  AST_SH_DUE: assert property (shWait < SH_LIMIT)
    else $error("No sample pulse in a conversion");
  AST_BUSY_HOLD: assert property ($rose(convBusy) |=> convBusy [*8])
    else $error("Conversion ended too soon");
endmodule : sar_adc_conversion_control_chk

bind sar_adc_conversion_control sar_adc_conversion_control_chk chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .analogSel(analogSel), .sampleHold(sampleHold), .convBusy(convBusy), .firstConv(firstConv));

// ===== verif/sar_adc_front_end.sv
// Purpose: Behavioural analog front end
// Assumes: Code is taken at the sample pulse and held to the end of conversion
// Notes: Outside a conversion the code drifts so a stale capture cannot match
module sar_adc_front_end
  import sar_adc_pkg::*;
(
  input wire logic ref_clk,                    // CPU clock
  input wire logic sampleHold,                 // Sample pulse
  input wire logic convBusy,                   // Conversion running
  input wire sar_adc_pkg::analog_sel_t analogSel, // Selection
  output logic [9:0] resultIn                  // Code
);
  logic [9:0] held_q = 10'h000;
  logic [9:0] noise_q = 10'h000;
  logic busy_q = 1'h0;
  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // frozen at sample
  always @(posedge ref_clk)
  begin
    busy_q <= convBusy;
    noise_q <= noise_q + 10'h0A5;
    if (sampleHold)
      held_q <= {analogSel, 4'h5};
  end
  assign resultIn = (convBusy || busy_q) ? held_q : ~held_q ^ noise_q;
endmodule : sar_adc_front_end

// ===== verif/sar_adc_conversion_control_tb.sv
// Purpose: Register level tests of the converter control
// Assumes: Divider select 0 gives two CPU cycles per converter cycle
// Notes: A monitor measures busy length and sample offset in CPU cycles
module sar_adc_conversion_control_tb;
  import sar_adc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [ADDR_W-1:0] avs_address = 5'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [TRIG_N-1:0] trigIn = 8'h00;
  logic cpuHalted = 1'h0;
  logic sleepNoiseMode = 1'h0;
  logic [9:0] resultIn;
  analog_sel_t analogSel;
  logic sampleHold, convBusy, firstConv, convIrq;
  logic [31:0] rdv;
  int n_errors = 0, checks = 0, cycles = 0, busyRun = 0, lastLen = 0, shOfs = 0, shAt = 0, nDone = 0, nSh = 0;
  int k, t0;
  sar_adc_conversion_control dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trigIn(trigIn), .cpuHalted(cpuHalted),
    .sleepNoiseMode(sleepNoiseMode), .resultIn(resultIn), .analogSel(analogSel), .sampleHold(sampleHold),
    .convBusy(convBusy), .firstConv(firstConv), .convIrq(convIrq));
  sar_adc_front_end fe (.ref_clk(ref_clk), .sampleHold(sampleHold), .convBusy(convBusy),
    .analogSel(analogSel), .resultIn(resultIn));
  always #4 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // Monitor and timeout
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (sampleHold === 1'h1)
    begin
      shOfs <= busyRun;
      shAt <= cycles;
      nSh <= nSh + 1;
    end
    if (convBusy === 1'h1)
      busyRun <= busyRun + 1;
    else if (busyRun != 0)
    begin
      lastLen <= busyRun;
      busyRun <= 0;
      nDone <= nDone + 1;
    end
    if (cycles == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    do
      @(posedge ref_clk);
    while (avs_waitrequest !== 1'h0);
    rdv = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic inrange(input int got, input int lo, input int hi);
    chk((got >= lo && got <= hi) ? lo : got, lo);
  endtask : inrange
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    bus(1'h1, a, d, 4'hF);
  endtask : wr
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    bus(1'h0, a, 8'h00, 4'hF);
    chk(rdv, exp);
  endtask : rdchk
  task automatic wait_for(input logic sh, input int n);
    while ((sh ? nSh : nDone) < n)
      @(posedge ref_clk);
  endtask : wait_for
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'h1;
    bus(1'h1, OFS_INSEL, 8'hFF, 4'hE);
    rdchk(OFS_INSEL, 32'h0);
    rdchk(OFS_CTRL_A, 32'h0);
    rdchk(OFS_CTRL_B, 32'h0);
    rdchk(OFS_POWER, 32'h0);
    rdchk(5'h18, 32'h0);
    $display("Test reset values done");
    wr(OFS_INSEL, 8'h43);
    wr(OFS_CTRL_A, 8'hC8);
    rdchk(OFS_CTRL_A, 32'hC8);
    chk({31'h0, firstConv}, 32'h1);
    wait_for(1'h0, 1);
    inrange(lastLen, 49, 51);
    inrange(shOfs, 26, 28);
    rdchk(OFS_CTRL_A, 32'h98);
    chk({31'h0, convIrq}, 32'h1);
    rdchk(OFS_RES_LO, 32'h35);
    rdchk(OFS_RES_HI, 32'h01);
    $display("Test first conversion done");
    wr(OFS_CTRL_A, 8'hD8);
    repeat (4) @(posedge ref_clk);
    wr(OFS_INSEL, 8'h47);
    wait_for(1'h0, 2);
    inrange(lastLen, 25, 27);
    inrange(shOfs, 2, 4);
    chk({26'h0, analogSel}, 32'h17);
    rdchk(OFS_RES_LO, 32'h35);
    wr(OFS_CTRL_A, 8'hD8);
    wait_for(1'h0, 3);
    rdchk(OFS_CTRL_A, 32'h98);
    rdchk(OFS_RES_HI, 32'h01);
    rdchk(OFS_RES_LO, 32'h35);
    rdchk(OFS_RES_HI, 32'h01);
    wr(OFS_CTRL_A, 8'hD8);
    wait_for(1'h0, 4);
    rdchk(OFS_RES_LO, 32'h75);
    rdchk(OFS_RES_HI, 32'h01);
    $display("Test channel change and blocking done");
    wr(OFS_CTRL_B, 8'h01);
    wr(OFS_CTRL_A, 8'hB0);
    k = nSh;
    @(posedge ref_clk);
    trigIn[1] <= 1'h1;
    t0 = cycles;
    wait_for(1'h1, k + 1);
    inrange(shAt - t0, 4, 10);
    trigIn[1] <= 1'h0;
    @(posedge ref_clk);
    trigIn[1] <= 1'h1;
    wait_for(1'h0, 5);
    repeat (60) @(posedge ref_clk);
    chk(nDone, 5);
    rdchk(OFS_CTRL_A, 32'hB0);
    chk({31'h0, convIrq}, 32'h0);
    trigIn[1] <= 1'h0;
    repeat (4) @(posedge ref_clk);
    trigIn[1] <= 1'h1;
    wait_for(1'h0, 6);
    $display("Test auto trigger done");
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_INSEL, 8'h41);
    k = nSh;
    wr(OFS_CTRL_A, 8'hF0);
    wait_for(1'h1, k + 2);
    wr(OFS_INSEL, 8'h45);
    rdchk(OFS_CTRL_A, 32'hF0);
    wait_for(1'h1, k + 3);
    rdchk(OFS_RES_LO, 32'h15);
    rdchk(OFS_RES_HI, 32'h01);
    wait_for(1'h1, k + 4);
    rdchk(OFS_RES_LO, 32'h55);
    rdchk(OFS_RES_HI, 32'h01);
    wr(OFS_CTRL_A, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, convBusy}, 32'h0);
    rdchk(OFS_CTRL_A, 32'h10);
    wr(OFS_INSEL, 8'h65);
    rdchk(OFS_RES_LO, 32'h40);
    rdchk(OFS_RES_HI, 32'h55);
    $display("Test free running done");
    k = nDone;
    wr(OFS_CTRL_A, 8'hD2);
    wait_for(1'h0, k + 1);
    inrange(lastLen, 99, 101);
    inrange(shOfs, 53, 55);
    wr(OFS_POWER, 8'h01);
    wr(OFS_CTRL_A, 8'hD8);
    repeat (10) @(posedge ref_clk);
    rdchk(OFS_CTRL_A, 32'h88);
    rdchk(OFS_POWER, 32'h01);
    wr(OFS_POWER, 8'h00);
    $display("Test divider done");
    wr(OFS_CTRL_A, 8'h98);
    k = nDone;
    cpuHalted <= 1'h1;
    repeat (40) @(posedge ref_clk);
    chk(nDone, k);
    rdchk(OFS_CTRL_A, 32'h88);
    cpuHalted <= 1'h0;
    sleepNoiseMode <= 1'h1;
    @(posedge ref_clk);
    cpuHalted <= 1'h1;
    repeat (6) @(posedge ref_clk);
    cpuHalted <= 1'h0;
    wait_for(1'h0, k + 1);
    chk({31'h0, convIrq}, 32'h1);
    $display("Test sleep start done");
    complete_run();
  end
endmodule : sar_adc_conversion_control_tb
